// >>> hw/mode_ctl_pkg.sv
// Shared constants for the CAN mode-request block
package mode_ctl_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [11:0] ADDR_CTL0 = 12'h000;
  localparam logic [11:0] ADDR_CTL1 = 12'h004;
  localparam logic [11:0] ADDR_RFLG = 12'h008;
  localparam logic [11:0] ADDR_RIER = 12'h00c;
  localparam logic [11:0] ADDR_TFLG = 12'h010;
  localparam logic [11:0] ADDR_TIER = 12'h014;
  localparam logic [11:0] ADDR_TARQ = 12'h018;
  localparam logic [11:0] ADDR_TAAK = 12'h01c;
  localparam logic [11:0] ADDR_TBSEL = 12'h020;
  localparam logic [11:0] ADDR_BTR0 = 12'h024;
  localparam logic [11:0] ADDR_BTR1 = 12'h028;
  localparam logic [11:0] ADDR_IDAC = 12'h02c;
  localparam logic [11:0] ADDR_STAT = 12'h030;
  localparam logic [11:0] ADDR_IDAR = 12'h040;
  localparam logic [11:0] ADDR_IDMR = 12'h060;
  localparam int ACC_REGS = 8;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTL0_INIT_REQ = 0;
  localparam int CTL0_SLEEP_REQ = 1;
  localparam int CTL0_WAKE_EN = 2;
  localparam int CTL0_STOP_IN_WAIT = 3;
  localparam int CTL1_INIT_ACK = 0;
  localparam int CTL1_SLEEP_ACK = 1;
  localparam int RFLG_WAKE_FLAG = 7;
  localparam int RIER_WAKE_IE = 7;
  localparam int STAT_BUSOFF = 0;
  localparam int STAT_SYNCED = 1;
  // ----------------------------------------
  // Reset values and field masks
  // ----------------------------------------
  localparam logic [7:0] RST_CTL0 = 8'h01;
  localparam logic [7:0] RST_CTL1 = 8'h11;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_TFLG = 8'h07;
  localparam logic [7:0] RST_BTR = 8'h00;
  localparam logic [7:0] RFLG_STAT_MASK = 8'h3c;
  localparam logic [7:0] RIER_STAT_MASK = 8'h3c;
  localparam logic [7:0] CTL0_KEEP_MASK = 8'h07;
  localparam logic [7:0] TFLG_EMPTY = 8'h07;
  // ----------------------------------------
  // Resync counts
  // ----------------------------------------
  localparam int IDLE_BITS = 11;
  localparam int BUSOFF_RUNS = 128;
  localparam logic [3:0] IDLE_BITS_M1 = 4'(IDLE_BITS - 1);
  localparam logic [7:0] BUSOFF_RUNS_M1 = 8'(BUSOFF_RUNS - 1);
  typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_INIT} mode_t;
endpackage

// >>> hw/bus_resync.sv
// Counts recessive runs to regain bus synchronization after restart
`timescale 1ns/100ps
module bus_resync (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic START,
  input wire logic BUS_OFF,
  input wire logic BIT_TICK,
  input wire logic RX_LEVEL,
  output logic SYNCED
);
  import mode_ctl_pkg::*;
  typedef struct packed {
    logic busy;
    logic synced;
    logic need_runs;
    logic [3:0] bits;
    logic [7:0] runs;
  } rs_t;
  rs_t s_q;
  rs_t s_d;
  assign SYNCED = s_q.synced;
  always_comb begin
    s_d = s_q;
    if (START) begin
      s_d.busy = 1'b1;
      s_d.synced = 1'b0;
      s_d.need_runs = BUS_OFF;
      s_d.bits = '0;
      s_d.runs = '0;
    end else if (s_q.busy && BIT_TICK) begin
      if (!RX_LEVEL) begin
        s_d.bits = '0;
      end else if (s_q.bits == IDLE_BITS_M1) begin
        s_d.bits = '0;
        if (!s_q.need_runs || s_q.runs == BUSOFF_RUNS_M1) begin
          s_d.busy = 1'b0;
          s_d.synced = 1'b1;
        end else begin
          s_d.runs = s_q.runs + 8'h01;
        end
      end else begin
        s_d.bits = s_q.bits + 4'h1;
      end
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      s_q <= '0;
    end else if (CE) begin
      s_q <= s_d;
    end
  end
endmodule // bus_resync

// >>> hw/can_mode_control.sv
// CAN controller mode request, grant and register protection logic
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/100ps
module can_mode_control (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RX_BUSY,
  input wire logic BUS_OFF,
  input wire logic BIT_TICK,
  input wire logic RX_PIN,
  input wire logic STOP_MODE,
  input wire logic WAIT_MODE,
  input wire logic CORE_TX,
  output logic TX_PIN,
  output logic ABORT_TRAFFIC,
  output logic SYNCED
);
  import mode_ctl_pkg::*;
  typedef struct packed {
    mode_t mode;
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [7:0] rflg;
    logic [7:0] rier;
    logic [7:0] tflg;
    logic [7:0] tier;
    logic [7:0] tarq;
    logic [7:0] taak;
    logic [7:0] tbsel;
    logic [7:0] btr0;
    logic [7:0] btr1;
    logic [7:0] idac;
    logic [ACC_REGS*8-1:0] idar;
    logic [ACC_REGS*8-1:0] idmr;
    logic [31:0] rdata;
    logic rx_meta;
    logic rx_sync;
    logic rx_prev;
    logic restart;
    logic tx;
  } st_t;
  st_t s_q;
  st_t s_d;
  logic wr;
  logic rd;
  logic known;
  logic [7:0] wb;
  logic in_init;
  logic bus_idle;
  logic [2:0] acc_idx;
  logic wake_edge;
  logic sleep_grant;
  logic stop_gate;
  logic resync_start;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    return a == b;
  endfunction
  function automatic logic in_bank(input logic [11:0] a,
                                   input logic [11:0] base);
    return a >= base && a < base + 12'(ACC_REGS * 4);
  endfunction

  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && !PENABLE && !PWRITE;
  assign wb = PWDATA[7:0];
  assign acc_idx = PADDR[4:2];
  assign in_init = s_q.mode == MODE_INIT;
  assign bus_idle = !RX_BUSY && (s_q.tflg & TFLG_EMPTY) == TFLG_EMPTY;
  assign sleep_grant = s_q.ctl0[CTL0_SLEEP_REQ] && bus_idle;
  // Falling edge of the synced bus level
  assign wake_edge = s_q.rx_prev && !s_q.rx_sync;
  assign stop_gate = STOP_MODE || (WAIT_MODE && s_q.ctl0[CTL0_STOP_IN_WAIT]);
  // Init holds the resync counter cleared
  assign resync_start = s_q.restart || in_init;
  assign known = hit(PADDR, ADDR_CTL0) || hit(PADDR, ADDR_CTL1) ||
    hit(PADDR, ADDR_RFLG) || hit(PADDR, ADDR_RIER) ||
    hit(PADDR, ADDR_TFLG) || hit(PADDR, ADDR_TIER) ||
    hit(PADDR, ADDR_TARQ) || hit(PADDR, ADDR_TAAK) ||
    hit(PADDR, ADDR_TBSEL) || hit(PADDR, ADDR_BTR0) ||
    hit(PADDR, ADDR_BTR1) || hit(PADDR, ADDR_IDAC) ||
    hit(PADDR, ADDR_STAT) || in_bank(PADDR, ADDR_IDAR) ||
    in_bank(PADDR, ADDR_IDMR);

  // Zero wait states: each access ends after its setup
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !known;
  assign PRDATA = s_q.rdata;
  assign TX_PIN = s_q.tx;
  assign ABORT_TRAFFIC = in_init;

  bus_resync u_resync (
    .REF_CLK(REF_CLK),
    .RST_N(RST_N),
    .CE(CE),
    .START(resync_start),
    .BUS_OFF(BUS_OFF),
    .BIT_TICK(BIT_TICK),
    .RX_LEVEL(s_q.rx_sync),
    .SYNCED(SYNCED)
  );

  always_comb begin
    s_d = s_q;
    s_d.rx_meta = RX_PIN;
    s_d.rx_sync = s_q.rx_meta;
    s_d.rx_prev = s_q.rx_sync;
    s_d.restart = 1'b0;
    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    if (wr) begin
      if (hit(PADDR, ADDR_CTL0)) begin
        s_d.ctl0[CTL0_WAKE_EN] = wb[CTL0_WAKE_EN];
        if (wb[CTL0_SLEEP_REQ] && !s_q.rflg[RFLG_WAKE_FLAG]) begin
          s_d.ctl0[CTL0_SLEEP_REQ] = 1'b1;
        end
        if (!wb[CTL0_SLEEP_REQ] && s_q.ctl0[CTL0_SLEEP_REQ] &&
            s_q.ctl1[CTL1_SLEEP_ACK]) begin
          s_d.ctl0[CTL0_SLEEP_REQ] = 1'b0;
        end
        if (wb[CTL0_INIT_REQ]) begin
          s_d.ctl0[CTL0_INIT_REQ] = 1'b1;
        end
        if (!wb[CTL0_INIT_REQ] && s_q.ctl0[CTL0_INIT_REQ] &&
            s_q.ctl1[CTL1_INIT_ACK]) begin
          s_d.ctl0[CTL0_INIT_REQ] = 1'b0;
        end
        s_d.ctl0[7:3] = wb[7:3];
      end
      if (hit(PADDR, ADDR_RFLG)) begin
        s_d.rflg = s_q.rflg & ~wb;
      end
      if (hit(PADDR, ADDR_RIER)) begin
        s_d.rier = wb;
      end
      if (hit(PADDR, ADDR_TFLG)) begin
        s_d.tflg = s_q.tflg | wb;
      end
      if (hit(PADDR, ADDR_TIER)) begin
        s_d.tier = wb;
      end
      if (hit(PADDR, ADDR_TARQ)) begin
        s_d.tarq = wb;
      end
      if (hit(PADDR, ADDR_TBSEL)) begin
        s_d.tbsel = wb;
      end
      if (in_init) begin
        if (hit(PADDR, ADDR_CTL1)) begin
          s_d.ctl1[7:2] = wb[7:2];
        end
        if (hit(PADDR, ADDR_BTR0)) begin
          s_d.btr0 = wb;
        end
        if (hit(PADDR, ADDR_BTR1)) begin
          s_d.btr1 = wb;
        end
        if (hit(PADDR, ADDR_IDAC)) begin
          s_d.idac = wb;
        end
        if (in_bank(PADDR, ADDR_IDAR)) begin
          s_d.idar[acc_idx*8 +: 8] = wb;
        end
        if (in_bank(PADDR, ADDR_IDMR)) begin
          s_d.idmr[acc_idx*8 +: 8] = wb;
        end
      end
    end
    // ----------------------------------------
    // Mode sequencing
    // ----------------------------------------
    case (s_q.mode)
      MODE_RUN: begin
        if (s_q.ctl0[CTL0_INIT_REQ]) begin
          s_d.mode = MODE_INIT;
          s_d.ctl1[CTL1_INIT_ACK] = 1'b1;
        end else if (sleep_grant) begin
          s_d.mode = MODE_SLEEP;
          s_d.ctl1[CTL1_SLEEP_ACK] = 1'b1;
        end
      end
      MODE_SLEEP: begin
        if (s_q.ctl0[CTL0_INIT_REQ]) begin
          s_d.mode = MODE_INIT;
          s_d.ctl1[CTL1_INIT_ACK] = 1'b1;
        end else if (s_q.ctl0[CTL0_WAKE_EN] && wake_edge) begin
          // Bus activity drops the request; sleep ends next cycle
          s_d.ctl0[CTL0_SLEEP_REQ] = 1'b0;
          s_d.rflg[RFLG_WAKE_FLAG] = 1'b1;
        end else if (!s_q.ctl0[CTL0_SLEEP_REQ]) begin
          s_d.mode = MODE_RUN;
          s_d.ctl1[CTL1_SLEEP_ACK] = 1'b0;
        end
      end
      MODE_INIT: begin
        if (!s_q.ctl0[CTL0_INIT_REQ]) begin
          s_d.mode = MODE_RUN;
          s_d.ctl1[CTL1_INIT_ACK] = 1'b0;
          s_d.ctl1[CTL1_SLEEP_ACK] = 1'b0;
          s_d.ctl0[CTL0_SLEEP_REQ] = 1'b0;
          // Leaving init restarts the resync counter
          s_d.restart = 1'b1;
        end else begin
          // Hold traffic registers at reset while in init
          s_d.ctl0 = (s_d.ctl0 & CTL0_KEEP_MASK) |
            (RST_CTL0 & ~CTL0_KEEP_MASK);
          s_d.rflg = (s_q.rflg & RFLG_STAT_MASK) |
            (RST_ZERO & ~RFLG_STAT_MASK);
          s_d.rier = (s_q.rier & RIER_STAT_MASK) |
            (RST_ZERO & ~RIER_STAT_MASK);
          s_d.tflg = RST_TFLG;
          s_d.tier = RST_ZERO;
          s_d.tarq = RST_ZERO;
          s_d.taak = RST_ZERO;
          s_d.tbsel = RST_ZERO;
        end
      end
      default: begin
        s_d.mode = MODE_INIT;
      end
    endcase
    // ----------------------------------------
    // Transmit pin gating
    // ----------------------------------------
    s_d.tx = CORE_TX;
    if (s_d.ctl0[CTL0_INIT_REQ] || s_q.ctl0[CTL0_INIT_REQ]) begin
      s_d.tx = 1'b1;
    end
    if (stop_gate) begin
      s_d.tx = 1'b1;
    end
    // ----------------------------------------
    // Read data
    // ----------------------------------------
    if (rd) begin
      s_d.rdata = '0;
      if (hit(PADDR, ADDR_CTL0)) s_d.rdata[7:0] = s_q.ctl0;
      if (hit(PADDR, ADDR_CTL1)) s_d.rdata[7:0] = s_q.ctl1;
      if (hit(PADDR, ADDR_RFLG)) s_d.rdata[7:0] = s_q.rflg;
      if (hit(PADDR, ADDR_RIER)) s_d.rdata[7:0] = s_q.rier;
      if (hit(PADDR, ADDR_TFLG)) s_d.rdata[7:0] = s_q.tflg;
      if (hit(PADDR, ADDR_TIER)) s_d.rdata[7:0] = s_q.tier;
      if (hit(PADDR, ADDR_TARQ)) s_d.rdata[7:0] = s_q.tarq;
      if (hit(PADDR, ADDR_TAAK)) s_d.rdata[7:0] = s_q.taak;
      if (hit(PADDR, ADDR_TBSEL)) s_d.rdata[7:0] = s_q.tbsel;
      if (hit(PADDR, ADDR_BTR0)) s_d.rdata[7:0] = s_q.btr0;
      if (hit(PADDR, ADDR_BTR1)) s_d.rdata[7:0] = s_q.btr1;
      if (hit(PADDR, ADDR_IDAC)) s_d.rdata[7:0] = s_q.idac;
      if (hit(PADDR, ADDR_STAT)) begin
        s_d.rdata[STAT_BUSOFF] = BUS_OFF;
        s_d.rdata[STAT_SYNCED] = SYNCED;
      end
      if (in_bank(PADDR, ADDR_IDAR)) s_d.rdata[7:0] = s_q.idar[acc_idx*8 +: 8];
      if (in_bank(PADDR, ADDR_IDMR)) s_d.rdata[7:0] = s_q.idmr[acc_idx*8 +: 8];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      s_q <= '0;
      s_q.mode <= MODE_INIT;
      s_q.ctl0 <= RST_CTL0;
      s_q.ctl1 <= RST_CTL1;
      s_q.tflg <= RST_TFLG;
      s_q.rx_meta <= 1'b1;
      s_q.rx_sync <= 1'b1;
      s_q.rx_prev <= 1'b1;
      s_q.tx <= 1'b1;
    end else if (CE) begin
      s_q <= s_d;
    end
  end
endmodule // can_mode_control

// >>> tb/can_bus_model.sv
// Bus-side model: bit ticks, bus level and receive activity
`timescale 1ns/100ps
module can_bus_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic dom,
  input wire logic busy,
  output logic rx_pin,
  output logic rx_busy,
  output logic bit_tick
);
  // Idle bus pulls to recessive
  always_ff @(posedge ref_clk) begin
    bit_tick <= rst_n & ~bit_tick;
    rx_pin <= ~dom;
    rx_busy <= busy;
  end
endmodule // can_bus_model

// >>> tb/can_mode_control_sva.sv
// Port checker for the CAN mode control block
`timescale 1ns/100ps
module can_mode_control_sva
  import mode_ctl_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [11:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic BUS_OFF,
  input wire logic BIT_TICK,
  input wire logic STOP_MODE,
  input wire logic TX_PIN,
  input wire logic ABORT_TRAFFIC,
  input wire logic SYNCED
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  logic [10:0] tick_cnt;
  logic boff_q;
  // Bit ticks since leaving init
  always_ff @(posedge REF_CLK) begin
    if (!RST_N || ABORT_TRAFFIC)
      tick_cnt <= '0;
    else if (BIT_TICK && tick_cnt != 11'h7ff)
      tick_cnt <= tick_cnt + 11'h001;
    if (ABORT_TRAFFIC)
      boff_q <= BUS_OFF;
  end
  chk_ready_high: assert property (PREADY)
    else $error("pready low");
  chk_err_unmapped: assert property (PSEL && PENABLE && PADDR == 12'h034
    |-> PSLVERR) else $error("no error on unmapped");
  chk_err_idle: assert property (!PENABLE |-> !PSLVERR)
    else $error("error outside access");
  chk_init_tx: assert property (ABORT_TRAFFIC |-> TX_PIN)
    else $error("tx dominant in init");
  chk_stop_tx: assert property (STOP_MODE |=> TX_PIN)
    else $error("tx dominant in stop");
  chk_init_sync: assert property (
    ABORT_TRAFFIC && $past(ABORT_TRAFFIC) |-> !SYNCED)
    else $error("sync kept in init");
  chk_resync_run: assert property (
    $rose(SYNCED) |-> tick_cnt >= IDLE_BITS - 1)
    else $error("resync too early");
  chk_resync_boff: assert property (
    $rose(SYNCED) && boff_q |-> tick_cnt >= IDLE_BITS * BUSOFF_RUNS - 1)
    else $error("bus-off resync too early");
  cover property ($fell(ABORT_TRAFFIC));
  cover property ($rose(SYNCED) && boff_q);
  cover property (STOP_MODE && !ABORT_TRAFFIC);
endmodule // can_mode_control_sva
bind can_mode_control can_mode_control_sva u_sva (.REF_CLK(REF_CLK),
  .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .BUS_OFF(BUS_OFF),
  .BIT_TICK(BIT_TICK), .STOP_MODE(STOP_MODE), .TX_PIN(TX_PIN),
  .ABORT_TRAFFIC(ABORT_TRAFFIC), .SYNCED(SYNCED));

// >>> tb/tb_top.sv
// Self-checking bench for the CAN mode control block
`timescale 1ns/100ps
module tb_top;
  import mode_ctl_pkg::*;
  typedef struct {logic [11:0] a; logic [8:0] e;} row_t;
  logic ref_clk, rst_n, psel, penable, pwrite, rx_busy, bus_off, bit_tick;
  logic rx_pin, stop_mode, wait_mode, core_tx, tx_pin, abort_traffic;
  logic synced, pready, pslverr, dom, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [8:0] q;
  int error_cnt, total_checks, i;
  row_t rows [10] = '{'{ADDR_CTL0, {1'b0, RST_CTL0}},
    '{ADDR_CTL1, {1'b0, RST_CTL1}}, '{ADDR_RFLG, 9'h000},
    '{ADDR_RIER, 9'h000}, '{ADDR_TFLG, {1'b0, RST_TFLG}},
    '{ADDR_TIER, 9'h000}, '{ADDR_TARQ, 9'h000}, '{ADDR_TAAK, 9'h000},
    '{ADDR_TBSEL, 9'h000}, '{12'h034, 9'h100}};
  can_mode_control u_dut (.REF_CLK(ref_clk), .RST_N(rst_n), .CE(1'b1),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RX_BUSY(rx_busy), .BUS_OFF(bus_off), .BIT_TICK(bit_tick),
    .RX_PIN(rx_pin), .STOP_MODE(stop_mode), .WAIT_MODE(wait_mode),
    .CORE_TX(core_tx), .TX_PIN(tx_pin), .ABORT_TRAFFIC(abort_traffic),
    .SYNCED(synced));
  can_bus_model u_bus (.ref_clk(ref_clk), .rst_n(rst_n), .dom(dom),
    .busy(busy), .rx_pin(rx_pin), .rx_busy(rx_busy), .bit_tick(bit_tick));
  initial begin
    ref_clk = 0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = {pslverr, prdata[7:0]};
    psel <= 0;
    penable <= 0;
  endtask
  task automatic poll(input logic [11:0] a, logic [7:0] m, logic [7:0] e);
    for (int k = 0; k < 20; k++) begin
      apb(0, a, 8'h00);
      if ((q[7:0] & m) === e)
        break;
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge ref_clk);
    error_cnt++;
    final_report();
  end
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, bus_off} = '0;
    {stop_mode, wait_mode, core_tx, dom, busy} = '0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1;
    foreach (rows[i]) begin
      apb(0, rows[i].a, 8'h00);
      chk(q, rows[i].e);
    end
    apb(1, ADDR_BTR0, 8'h5a);
    apb(0, ADDR_BTR0, 8'h00);
    chk(q, 9'h05a);
    apb(1, ADDR_CTL0, 8'h00);
    poll(ADDR_CTL1, 8'h01, 8'h00);
    chk(q & 9'h101, 9'h000);
    apb(1, ADDR_BTR0, 8'h33);
    apb(0, ADDR_BTR0, 8'h00);
    chk(q, 9'h05a);
    for (i = 0; i < 200 && synced !== 1'b1; i++) @(posedge ref_clk);
    chk(synced, 1);
    $display("end config and restart");
    busy <= 1;
    apb(1, ADDR_TIER, 8'h05);
    apb(1, ADDR_CTL0, 8'h02);
    poll(ADDR_CTL1, 8'h02, 8'h02);
    chk(q & 9'h002, 9'h000);
    apb(1, ADDR_CTL0, 8'h00);
    apb(0, ADDR_CTL0, 8'h00);
    chk(q & 9'h002, 9'h002);
    busy <= 0;
    poll(ADDR_CTL1, 8'h02, 8'h02);
    chk(q & 9'h002, 9'h002);
    apb(1, ADDR_CTL0, 8'h00);
    poll(ADDR_CTL1, 8'h02, 8'h00);
    chk(q & 9'h002, 9'h000);
    $display("end sleep");
    apb(1, ADDR_CTL0, 8'h06);
    poll(ADDR_CTL1, 8'h02, 8'h02);
    dom <= 1;
    poll(ADDR_CTL0, 8'h02, 8'h00);
    chk(q & 9'h002, 9'h000);
    dom <= 0;
    apb(0, ADDR_RFLG, 8'h00);
    chk(q & 9'h080, 9'h080);
    apb(1, ADDR_CTL0, 8'h06);
    apb(0, ADDR_CTL0, 8'h00);
    chk(q & 9'h002, 9'h000);
    apb(1, ADDR_RFLG, 8'h80);
    $display("end wakeup");
    apb(1, ADDR_CTL0, 8'h08);
    chk(tx_pin, 0);
    stop_mode <= 1;
    repeat (2) @(posedge ref_clk);
    chk(tx_pin, 1);
    stop_mode <= 0;
    wait_mode <= 1;
    repeat (2) @(posedge ref_clk);
    chk(tx_pin, 1);
    wait_mode <= 0;
    apb(1, ADDR_CTL0, 8'h00);
    wait_mode <= 1;
    repeat (2) @(posedge ref_clk);
    chk(tx_pin, 0);
    wait_mode <= 0;
    $display("end stop and wait");
    apb(1, ADDR_CTL0, 8'h06);
    poll(ADDR_CTL1, 8'h02, 8'h02);
    apb(1, ADDR_CTL0, 8'h07);
    repeat (3) @(posedge ref_clk);
    chk({tx_pin, abort_traffic, synced}, 9'h006);
    poll(ADDR_CTL1, 8'h01, 8'h01);
    chk(q & 9'h001, 9'h001);
    apb(0, ADDR_TIER, 8'h00);
    chk(q, 9'h000);
    apb(0, ADDR_CTL0, 8'h00);
    chk(q & 9'h00f, 9'h007);
    $display("end init entry");
    bus_off <= 1;
    apb(1, ADDR_CTL0, 8'h00);
    for (i = 0; i < 5000 && synced !== 1'b1; i++) @(posedge ref_clk);
    chk(9'(i > 2 * IDLE_BITS * (BUSOFF_RUNS - 1) && synced === 1), 1);
    $display("end bus-off restart");
    rst_n <= 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1;
    @(posedge ref_clk);
    chk({tx_pin, abort_traffic, synced}, 9'h006);
    apb(0, ADDR_CTL0, 8'h00);
    chk(q, {1'b0, RST_CTL0});
    $display("end mid-run reset");
    final_report();
  end
endmodule // tb_top
